// >>> inc/tlpar_cfg.svh
// constants for the transaction acceptance and routing block
//
// Notes on behaviour
// [R1] messages pass regardless of bus master, power
// [R2] completer abort only for claimed, broken requests
// [R3] non-D0 bridge: downstream memory/io requests unsupported
// [R4] non-D0: type 1 config unsupported, type 0 unaffected
// [R5] completions pass in any power state
// [R6] completion matching no outstanding tag is unexpected
// [R7] tag match but other mismatch may be unexpected
// [R8] switch processes routing 100b, reserved, or known codes
// [R9] only the ack message may use routing 101b
// [R10] ack message must not arrive at upstream port
// [R11] optional routing checks report malformed on receiver
// [R12] switch credits: min of payload/unit and read size
// [R13] endpoints advertise infinite credits as all zeros
// [R14] downstream ports accept posted/completion without non-posted
// [R15] upstream port accepts posted/completion without downstream non-posted
// [R16] upstream accepts posted without own transmission
// [R17] upstream accepts non-posted without own non-posted
// [R18] completions always accepted, never stalled
// [R19] completion uses the request's traffic class
// [R20] interrupt disable bit stops and deasserts own interrupts
// [R21] forwarded interrupt messages ignore the disable bit
// [R22] without own interrupts the disable bit reads zero
// [R23] unsupported non-posted request gets unsupported completion
// [R24] unexpected completions dropped and flagged, tracking untouched
`ifndef TLPAR_CFG_SVH
`define TLPAR_CFG_SVH
`define TLPAR_ADDR_CMD 12'h004
`define TLPAR_ADDR_CTRL 12'h008
`define TLPAR_ADDR_STAT 12'h00C
`define TLPAR_ADDR_TRACK 12'h010
`define TLPAR_ADDR_CRED 12'h014
`define TLPAR_CMD_MASK 16'h0407
`define TLPAR_BIT_INTDIS 10
`define TLPAR_BIT_BME 2
`define TLPAR_ROUTE_LOCAL 3'h4
`define TLPAR_ROUTE_GATHER 3'h5
`define TLPAR_MSG_ACK 8'h1B
`define TLPAR_CPL_SC 3'h0
`define TLPAR_CPL_UR 3'h1
`define TLPAR_CPL_CA 3'h4
`define TLPAR_FC_UNIT_SH 4
`endif

// >>> inc/tlpar_pkg.sv
// types shared by the transaction acceptance and routing block
package tlpar_pkg;
  typedef enum logic [2:0] {tlpar_k_mem, tlpar_k_io, tlpar_k_cfg0, tlpar_k_cfg1,
    tlpar_k_msg, tlpar_k_cpl} tlpar_kind_type;
  // one received packet header
  typedef struct packed {
    tlpar_kind_type kind;
    logic posted;
    logic downstream;
    logic [2:0] tc;
    logic [7:0] tag;
    logic [2:0] route;
    logic [7:0] msg_code;
    logic msg_known;
    logic claimed;
    logic broken;
    logic other_mismatch;
  } tlpar_hdr_type;
  // verdict on a packet
  typedef struct packed {
    logic accept;
    logic unsupported;
    logic send_cpl;
    logic [2:0] cpl_status;
    logic [2:0] cpl_tc;
    logic [7:0] cpl_tag;
    logic local_msg;
    logic malformed;
    logic unexpected;
  } tlpar_verdict_type;
endpackage : tlpar_pkg

// >>> logic/tlpar_core.sv
// packet acceptance, routing checks, credits and legacy interrupt control
`include "tlpar_cfg.svh"
module tlpar_core #(
  parameter int TAGS = 32,
  parameter bit IS_SWITCH = 1'b1,
  parameter bit IS_UPSTREAM = 1'b0,
  parameter bit HAS_OWN_INTX = 1'b1,
  parameter bit CHECK_ROUTES = 1'b1,
  parameter logic [11:0] MAX_PAYLOAD_BYTES = 12'h200,
  parameter logic [11:0] MAX_READ_BYTES = 12'h200
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // received packets
  input wire logic rx_valid,
  input wire tlpar_pkg::tlpar_hdr_type rx_hdr,
  output logic rx_ready,
  // verdict out
  output tlpar_pkg::tlpar_verdict_type verdict,
  output logic verdict_valid,
  // request issue tracking
  input wire logic req_issue,
  input wire logic [7:0] req_issue_tag,
  // own legacy interrupt and forwarded messages
  input wire logic intx_req,
  input wire logic fwd_intx_valid,
  input wire logic fwd_intx_assert,
  output logic intx_msg_valid,
  output logic intx_msg_assert,
  output logic intx_msg_own,
  // advertised non-posted data credits
  output logic [11:0] np_credit
);
  // ------------------------------------------------------------
  // register slave
  // ------------------------------------------------------------
  logic [15:0] cmd_r;
  logic d0_n_r;
  logic [31:0] stat_r;
  logic [31:0] stat_nxt;
  logic [TAGS-1:0] track_r;
  logic [TAGS-1:0] track_nxt;
  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] hrdata_r;

  wire logic take = hsel && hready && htrans[1];
  wire logic do_wr = wr_pend_r;
  wire logic wr_cmd = do_wr && (wr_addr_r == `TLPAR_ADDR_CMD);
  wire logic wr_ctrl = do_wr && (wr_addr_r == `TLPAR_ADDR_CTRL);
  wire logic wr_stat = do_wr && (wr_addr_r == `TLPAR_ADDR_STAT);
  wire logic [15:0] cmd_wmask = HAS_OWN_INTX ? `TLPAR_CMD_MASK :
    (`TLPAR_CMD_MASK & ~(16'h0001 << `TLPAR_BIT_INTDIS)); // see [R22]
  wire logic int_dis = cmd_r[`TLPAR_BIT_INTDIS];

  // credit minimum: payload in units vs read request size
  wire logic [11:0] pay_units = MAX_PAYLOAD_BYTES >> `TLPAR_FC_UNIT_SH;
  wire logic [11:0] rd_units = MAX_READ_BYTES >> `TLPAR_FC_UNIT_SH;
  assign np_credit = IS_SWITCH ? ((pay_units < rd_units) ? pay_units : rd_units) // see [R12]
    : 12'h000; // see [R13]

  function automatic logic [31:0] rd_mux(input logic [11:0] a, input logic [15:0] c,
    input logic d, input logic [31:0] s, input logic [31:0] t, input logic [11:0] n);
    case (a)
      `TLPAR_ADDR_CMD: rd_mux = {16'h0000, c};
      `TLPAR_ADDR_CTRL: rd_mux = {31'h00000000, d};
      `TLPAR_ADDR_STAT: rd_mux = s;
      `TLPAR_ADDR_TRACK: rd_mux = t;
      `TLPAR_ADDR_CRED: rd_mux = {20'h00000, n};
      default: rd_mux = 32'h00000000;
    endcase
  endfunction : rd_mux

  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // address phase capture and read data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= take && hwrite;
      wr_addr_r <= haddr[11:0];
      if (take && !hwrite) begin
        hrdata_r <= rd_mux(haddr[11:0], cmd_r, d0_n_r, stat_r, 32'(track_r), np_credit);
      end
    end
  end

  // command and power state registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_r <= 16'h0000; // see [R20]
      d0_n_r <= 1'b0;
    end else begin
      if (wr_cmd) begin
        cmd_r <= hwdata[15:0] & cmd_wmask;
      end
      if (wr_ctrl) begin
        d0_n_r <= hwdata[0];
      end
    end
  end

  // ------------------------------------------------------------
  // packet classification
  // ------------------------------------------------------------
  wire logic is_cpl = rx_hdr.kind == tlpar_pkg::tlpar_k_cpl;
  wire logic is_msg = rx_hdr.kind == tlpar_pkg::tlpar_k_msg;
  wire logic is_memio = (rx_hdr.kind == tlpar_pkg::tlpar_k_mem) ||
    (rx_hdr.kind == tlpar_pkg::tlpar_k_io);
  wire logic is_cfg1 = rx_hdr.kind == tlpar_pkg::tlpar_k_cfg1;
  // power filter touches only requests, never messages or completions
  wire logic pm_block = d0_n_r && ((is_memio && rx_hdr.downstream) || is_cfg1); // see [R3] [R4]
  wire logic tag_ok = (rx_hdr.tag < 8'(TAGS)) && track_r[rx_hdr.tag[$clog2(TAGS)-1:0]];
  wire logic unexp = is_cpl && (!tag_ok || rx_hdr.other_mismatch); // see [R6] [R7]
  wire logic is_ack = rx_hdr.msg_code == `TLPAR_MSG_ACK;
  wire logic bad_gather = is_msg && (rx_hdr.route == `TLPAR_ROUTE_GATHER) && !is_ack; // see [R9]
  wire logic bad_ack = is_msg && is_ack && IS_UPSTREAM; // see [R10]
  wire logic malformed = IS_SWITCH && CHECK_ROUTES && (bad_gather || bad_ack); // see [R11]
  wire logic local_msg = is_msg && !malformed && (rx_hdr.route == `TLPAR_ROUTE_LOCAL ||
    rx_hdr.route > `TLPAR_ROUTE_GATHER || rx_hdr.msg_known); // see [R8]
  // messages bypass bus master enable and power state entirely
  wire logic unsup = !is_cpl && !is_msg && (pm_block || !rx_hdr.claimed); // see [R1] [R5]
  wire logic abort = !is_cpl && !is_msg && !unsup && rx_hdr.broken; // see [R2]
  wire logic want_cpl = !is_cpl && !is_msg && !rx_hdr.posted;

  // acceptance never waits on any transmission; always ready
  assign rx_ready = 1'b1; // see [R14] [R15] [R16] [R17] [R18]
  wire logic rx_fire = rx_valid && rx_ready;

  // ------------------------------------------------------------
  // verdict and tracking
  // ------------------------------------------------------------
  tlpar_pkg::tlpar_verdict_type v_nxt;
  always_comb begin
    v_nxt.accept = !unexp && !malformed;
    v_nxt.unsupported = unsup;
    v_nxt.send_cpl = want_cpl;
    v_nxt.cpl_status = unsup ? `TLPAR_CPL_UR : (abort ? `TLPAR_CPL_CA : `TLPAR_CPL_SC); // see [R23]
    v_nxt.cpl_tc = rx_hdr.tc; // see [R19]
    v_nxt.cpl_tag = rx_hdr.tag;
    v_nxt.local_msg = local_msg;
    v_nxt.malformed = malformed;
    v_nxt.unexpected = unexp;
  end

  // unexpected completions leave tracking alone; issue wins over retire
  always_comb begin
    track_nxt = track_r;
    if (rx_fire && is_cpl && !unexp) begin
      track_nxt[rx_hdr.tag[$clog2(TAGS)-1:0]] = 1'b0; // see [R24]
    end
    if (req_issue && (req_issue_tag < 8'(TAGS))) begin
      track_nxt[req_issue_tag[$clog2(TAGS)-1:0]] = 1'b1;
    end
  end

  // sticky status: bit0 unexpected, bit1 malformed, bit2 unsupported; set beats clear
  always_comb begin
    stat_nxt = stat_r;
    if (wr_stat) begin
      stat_nxt = stat_r & ~hwdata;
    end
    if (rx_fire) begin
      stat_nxt[0] = stat_nxt[0] | unexp; // see [R24]
      stat_nxt[1] = stat_nxt[1] | malformed; // see [R11]
      stat_nxt[2] = stat_nxt[2] | unsup;
    end
    stat_nxt[31:3] = 29'h00000000;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      verdict <= '0;
      verdict_valid <= 1'b0;
      track_r <= '0;
      stat_r <= 32'h00000000;
    end else begin
      verdict_valid <= rx_fire;
      if (rx_fire) begin
        verdict <= v_nxt;
      end
      track_r <= track_nxt;
      stat_r <= stat_nxt;
    end
  end

  // ------------------------------------------------------------
  // legacy interrupt messages
  // ------------------------------------------------------------
  logic intx_sent_r;
  wire logic own_want = intx_req && !int_dis && HAS_OWN_INTX; // see [R20]
  wire logic own_chg = own_want != intx_sent_r; // disable forces deassert
  // forwarded messages take priority and ignore the disable bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      intx_sent_r <= 1'b0;
      intx_msg_valid <= 1'b0;
      intx_msg_assert <= 1'b0;
      intx_msg_own <= 1'b0;
    end else begin
      intx_msg_valid <= fwd_intx_valid || own_chg;
      intx_msg_own <= !fwd_intx_valid && own_chg;
      if (fwd_intx_valid) begin
        intx_msg_assert <= fwd_intx_assert; // see [R21]
      end else if (own_chg) begin
        intx_msg_assert <= own_want;
        intx_sent_r <= own_want;
      end
    end
  end
endmodule : tlpar_core

// >>> tb/tb_top.sv
// bench: registers, packets and interrupts of the routing block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, hsel, hwrite, rxv, vv, req_issue, intx_req, fwd_v, fwd_a;
  logic hrdy, hresp, rx_ready, im_v, im_a, im_o, pwr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] itag;
  logic [11:0] np_credit;
  logic [31:0] haddr, hwdata, hrdata, rd, outst, st;
  tlpar_pkg::tlpar_hdr_type rxh, h;
  tlpar_pkg::tlpar_verdict_type verdict, e, g;
  tlpar_pkg::tlpar_verdict_type exp_q[$];
  logic own_q[$];
  int error_cnt, check_count, cyc, seed, i;
  tlpar_partner lp (.clk(clk), .rx_valid(rxv), .rx_hdr(rxh));
  tlpar_core #(.MAX_READ_BYTES(12'h100)) uut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .rx_valid(rxv),
    .rx_hdr(rxh), .rx_ready(rx_ready), .verdict(verdict), .verdict_valid(vv),
    .req_issue(req_issue), .req_issue_tag(itag), .intx_req(intx_req),
    .fwd_intx_valid(fwd_v), .fwd_intx_assert(fwd_a), .intx_msg_valid(im_v),
    .intx_msg_assert(im_a), .intx_msg_own(im_o), .np_credit(np_credit));
  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] y);
    check_count++;
    if (y !== x) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, x, y);
    end
  endtask : cmp
  task automatic conclude();
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // single word transfer, entered right after an edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
    cmp("response", 32'h0, 32'(hresp));
  endtask : bus
  // back-to-back issue pulses on random tags within the tracked range
  task automatic issue(input int n);
    repeat (n) begin
      @(posedge clk);
      h = 31'($random(seed));
      req_issue <= 1'b1;
      itag <= {3'h0, h.tag[4:0]};
      outst[h.tag[4:0]] = 1'b1;
    end
    @(posedge clk);
    req_issue <= 1'b0;
  endtask : issue
  // reference verdict; retires a tag the way the receiver should
  function automatic tlpar_pkg::tlpar_verdict_type model(input tlpar_pkg::tlpar_hdr_type p);
    tlpar_pkg::tlpar_verdict_type v;
    logic rq;
    v = '0;
    rq = p.kind < tlpar_pkg::tlpar_k_msg;
    v.unsupported = rq && (!p.claimed || (pwr && (p.kind == tlpar_pkg::tlpar_k_cfg1
      || (p.downstream && p.kind < tlpar_pkg::tlpar_k_cfg0))));
    v.send_cpl = rq && !p.posted;
    // a request that is not unsupported is claimed, so abort needs only the fault
    v.cpl_status = v.unsupported ? 3'h1 : (rq && p.broken) ? 3'h4 : 3'h0;
    v.cpl_tc = p.tc;
    v.cpl_tag = p.tag;
    if (p.kind == tlpar_pkg::tlpar_k_msg) begin
      v.malformed = p.route == 3'h5 && p.msg_code != 8'h1B;
      // a malformed message is never handled locally
      v.local_msg = !v.malformed &&
        (p.route == 3'h4 || p.route > 3'h5 || p.msg_known);
    end
    if (p.kind == tlpar_pkg::tlpar_k_cpl) begin
      v.unexpected = !outst[p.tag[4:0]] || p.other_mismatch;
      if (!v.unexpected) outst[p.tag[4:0]] = 1'b0;
    end
    v.accept = !v.unexpected && !v.malformed;
    st = st | {29'h0, v.unsupported, v.malformed, v.unexpected};
    return v;
  endfunction : model
  // random headers cycling through every packet kind
  task automatic burst(input int n);
    for (i = 0; i < n; i++) begin
      h = 31'($random(seed));
      h.kind = tlpar_pkg::tlpar_kind_type'(i % 6);
      h.tag[7:5] = 3'h0;
      if (h.tc[0]) h.msg_code = 8'h1B;
      exp_q.push_back(model(h));
      @(posedge clk);
      lp.send(h);
    end
    @(posedge clk);
    lp.idle();
  endtask : burst
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  // whole verdicts compare in send order
  always @(posedge clk) begin
    if (vv === 1'b1) begin
      e = exp_q.pop_front();
      g = verdict;
      cmp("verdict", 32'(e), 32'(g));
    end
    if (im_v === 1'b1 && im_o === 1'b1) own_q.push_back(im_a);
  end
  initial begin
    {reset_n, hwrite, req_issue, intx_req, fwd_v, fwd_a, pwr, hsel} = 8'h01;
    {htrans, haddr, hwdata, itag, outst, st, cyc, error_cnt, check_count} = '0;
    hsize = 3'h2;
    seed = 92184;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 12'h004, 32'h0);
    cmp("command", 32'h0, rd);
    intx_req <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b1, 12'h004, 32'hFFFF);
    bus(1'b0, 12'h004, 32'h0);
    cmp("command", 32'h407, rd);
    intx_req <= 1'b0;
    repeat (3) @(posedge clk);
    intx_req <= 1'b1;
    fwd_v <= 1'b1;
    fwd_a <= 1'b1;
    @(posedge clk);
    fwd_v <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("own count", 32'h2, own_q.size());
    cmp("own assert", 32'h1, 32'(own_q[0]));
    cmp("own deassert", 32'h0, 32'(own_q[1]));
    bus(1'b0, 12'h014, 32'h0);
    cmp("credit", 32'h10, rd);
    cmp("np_credit", 32'h10, 32'(np_credit));
    bus(1'b0, 12'h100, 32'h0);
    cmp("unmapped", 32'h0, rd);
    issue(12);
    burst(60);
    bus(1'b0, 12'h010, 32'h0);
    cmp("tracking", outst, rd);
    // sticky status collects every flag of the burst, then clears by write-one
    bus(1'b0, 12'h00C, 32'h0);
    cmp("status", st, rd);
    bus(1'b1, 12'h00C, 32'h7);
    bus(1'b0, 12'h00C, 32'h0);
    cmp("status clear", 32'h0, rd);
    st = '0;
    bus(1'b1, 12'h008, 32'h1);
    bus(1'b0, 12'h008, 32'h0);
    cmp("control", 32'h1, rd);
    pwr = 1'b1;
    issue(8);
    burst(60);
    bus(1'b0, 12'h010, 32'h0);
    cmp("tracking", outst, rd);
    bus(1'b0, 12'h00C, 32'h0);
    cmp("status", st, rd);
    cmp("left", 32'h0, exp_q.size());
    conclude();
  end
endmodule : tb_top

// >>> tb/tlpar_checker.sv
// port assertions for the routing block
module tlpar_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // packets and verdicts
  input wire logic rx_valid,
  input wire tlpar_pkg::tlpar_hdr_type rx_hdr,
  input wire logic rx_ready,
  input wire tlpar_pkg::tlpar_verdict_type verdict,
  input wire logic verdict_valid,
  // interrupt messages
  input wire logic fwd_intx_valid,
  input wire logic fwd_intx_assert,
  input wire logic intx_msg_valid,
  input wire logic intx_msg_assert,
  input wire logic intx_msg_own
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // packet class taken this cycle
  wire logic is_cpl = rx_valid && rx_hdr.kind == tlpar_pkg::tlpar_k_cpl;
  wire logic is_msg = rx_valid && rx_hdr.kind == tlpar_pkg::tlpar_k_msg;
  chk_verdict_time: assert property (verdict_valid == $past(rx_valid))
    else $error("verdict pulse late");
  chk_never_stall: assert property (rx_ready)
    else $error("packet refused");
  chk_cpl_class: assert property (rx_valid |=> verdict.cpl_tc == $past(rx_hdr.tc))
    else $error("completion class differs");
  chk_cpl_pass: assert property (is_cpl |=> !verdict.unsupported)
    else $error("completion refused");
  chk_msg_pass: assert property (is_msg |=> !verdict.unsupported)
    else $error("message refused");
  chk_abort_claim: assert property (rx_valid && !rx_hdr.claimed
    |=> verdict.cpl_status != 3'h4)
    else $error("abort on unclaimed request");
  chk_gather_code: assert property (is_msg && rx_hdr.route == 3'h5
    && rx_hdr.msg_code != 8'h1B |=> verdict.malformed)
    else $error("gather route not flagged");
  chk_fwd_intx: assert property (fwd_intx_valid |=> intx_msg_valid && !intx_msg_own
    && intx_msg_assert == $past(fwd_intx_assert))
    else $error("forwarded interrupt lost");
  // a completion that differs from its request is dropped, never retired
  chk_mismatch_drop: assert property (is_cpl && rx_hdr.other_mismatch
    |=> verdict.unexpected && !verdict.accept)
    else $error("mismatched completion kept");
endmodule : tlpar_checker
bind tlpar_core tlpar_checker u_chk (.clk(clk), .reset_n(reset_n), .rx_valid(rx_valid),
  .rx_hdr(rx_hdr), .rx_ready(rx_ready), .verdict(verdict), .verdict_valid(verdict_valid),
  .fwd_intx_valid(fwd_intx_valid), .fwd_intx_assert(fwd_intx_assert),
  .intx_msg_valid(intx_msg_valid), .intx_msg_assert(intx_msg_assert),
  .intx_msg_own(intx_msg_own));

// >>> tb/tlpar_partner.sv
// link partner model feeding packet headers
module tlpar_partner (
  // clock
  input wire logic clk,
  // headers toward the block
  output logic rx_valid,
  output tlpar_pkg::tlpar_hdr_type rx_hdr
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle at time zero
  initial begin
    rx_valid = 1'b0;
    rx_hdr = '0;
  end
  // calls on consecutive edges give back-to-back traffic
  task automatic send(input tlpar_pkg::tlpar_hdr_type p);
    rx_valid <= 1'b1;
    rx_hdr <= p;
  endtask : send
  // released lines invert so a stale header never looks valid
  task automatic idle();
    rx_valid <= 1'b0;
    rx_hdr <= ~rx_hdr;
  endtask : idle
endmodule : tlpar_partner
